// ### rtl/ivcc_port.sv
// I2C control port and control state of a voltage-programmable regulator.
// Assumes a 40 MHz clk, open-drain SDA resolved outside, SCL driven by master.
`timescale 1ns/100ps
`default_nettype none

module ivcc_port
#(
   parameter logic [6:0] DEVICE_ADDR = 7'h36,
   parameter int SOFT_START_CYCLES = ivcc_pkg::SOFT_START_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // Regulator status pins
   input wire logic enable_pin,
   input wire logic supply_ok,
   input wire logic fault,
   // Regulator control outputs
   output logic [6:0] voltage_code,
   output logic use_register_code,
   output logic use_initial_setpoint_pin,
   output logic protection_suspend,
   output logic light_load_select,
   output logic latch_off_mode,
   output logic regulator_on,
   output logic power_ok
);

   logic scl;
   logic sda;
   logic scl_d;
   logic sda_d;
   logic start_cond;
   logic stop_cond;
   logic scl_rise;
   logic scl_fall;
   logic en_lvl;
   logic sup_lvl;
   logic flt_lvl;
   ivcc_pkg::ivcc_state_t state;
   ivcc_pkg::ivcc_state_t ret_state;
   logic [3:0] bit_cnt;
   logic [7:0] shreg;
   logic [7:0] reg_ptr;
   logic read_dir;
   logic ack_now;
   logic [7:0] output_voltage_code;
   logic [7:0] regulator_control;
   logic [7:0] rd_byte;
   logic code_change;
   logic latched_off;
   logic en_prev;
   logic [31:0] ss_cnt;

   // Parity check: bit 7 must be XNOR of the seven code bits.
   function automatic logic parity_ok(input logic [7:0] b);
      parity_ok = (b[ivcc_pkg::PARITY_BIT] == ~^b[6:0]);
   endfunction

   // ==========================================================
   // Input synchronisers
   ivcc_sync #(.RESET_LEVEL(1'b1)) u_scl (.clk(clk), .rst_n(rst_n), .pin(scl_in), .level(scl));
   ivcc_sync #(.RESET_LEVEL(1'b1)) u_sda (.clk(clk), .rst_n(rst_n), .pin(sda_in), .level(sda));
   ivcc_sync #(.RESET_LEVEL(1'b0)) u_en (.clk(clk), .rst_n(rst_n), .pin(enable_pin),
      .level(en_lvl));
   ivcc_sync #(.RESET_LEVEL(1'b0)) u_sup (.clk(clk), .rst_n(rst_n), .pin(supply_ok),
      .level(sup_lvl));
   ivcc_sync #(.RESET_LEVEL(1'b0)) u_flt (.clk(clk), .rst_n(rst_n), .pin(fault),
      .level(flt_lvl));

   // Previous line levels for edge and condition detection.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         scl_d <= 1'b1;
         sda_d <= 1'b1;
      end
      else
      begin
         scl_d <= scl;
         sda_d <= sda;
      end
   end

   // Bus events; the filtered SCL period is far longer than this path.
   assign start_cond = scl && scl_d && sda_d && !sda;
   assign stop_cond = scl && scl_d && !sda_d && sda;
   assign scl_rise = scl && !scl_d;
   assign scl_fall = !scl && scl_d;

   // Read-back byte selected by the register pointer.
   assign rd_byte = (reg_ptr == ivcc_pkg::ADDR_CONTROL) ? regulator_control
      : output_voltage_code;

   // ==========================================================
   // Serial state machine: bit counting, shifting and ACK decisions.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state <= ivcc_pkg::IVCC_IDLE;
         ret_state <= ivcc_pkg::IVCC_IDLE;
         bit_cnt <= 4'h0;
         shreg <= 8'h00;
         reg_ptr <= 8'h00;
         read_dir <= 1'b0;
         ack_now <= 1'b0;
      end
      else if (!en_lvl || stop_cond)
      begin
         state <= ivcc_pkg::IVCC_IDLE;
         ack_now <= 1'b0;
      end
      else if (start_cond)
      begin
         state <= ivcc_pkg::IVCC_ADDR;
         bit_cnt <= 4'h0;
         ack_now <= 1'b0;
      end
      else if (scl_rise && state != ivcc_pkg::IVCC_IDLE && state != ivcc_pkg::IVCC_SKIP
         && bit_cnt != 4'h8)
      begin
         shreg <= (state == ivcc_pkg::IVCC_RDATA) ? shreg : {shreg[6:0], sda};
         bit_cnt <= bit_cnt + 4'h1;
      end
      else if (scl_fall)
      begin
         case (state)
            ivcc_pkg::IVCC_ADDR:
            begin
               if (bit_cnt == 4'h8)
               begin
                  if (shreg[7:1] == DEVICE_ADDR)
                  begin
                     read_dir <= shreg[0];
                     ack_now <= 1'b1;
                     state <= ivcc_pkg::IVCC_ACK;
                     ret_state <= shreg[0] ? ivcc_pkg::IVCC_RDATA : ivcc_pkg::IVCC_REG;
                     shreg <= rd_byte;
                  end
                  else
                     state <= ivcc_pkg::IVCC_SKIP;
               end
            end
            ivcc_pkg::IVCC_REG:
            begin
               if (bit_cnt == 4'h8)
               begin
                  reg_ptr <= shreg;
                  ack_now <= 1'b1;
                  state <= ivcc_pkg::IVCC_ACK;
                  ret_state <= ivcc_pkg::IVCC_WDATA;
               end
            end
            ivcc_pkg::IVCC_WDATA:
            begin
               if (bit_cnt == 4'h8)
               begin
                  // Voltage bytes must pass parity; unknown pointers are refused.
                  if ((reg_ptr == ivcc_pkg::ADDR_VOLTAGE && parity_ok(shreg))
                     || reg_ptr == ivcc_pkg::ADDR_CONTROL)
                  begin
                     ack_now <= 1'b1;
                     state <= ivcc_pkg::IVCC_ACK;
                     ret_state <= ivcc_pkg::IVCC_SKIP;
                  end
                  else
                     state <= ivcc_pkg::IVCC_SKIP;
               end
            end
            ivcc_pkg::IVCC_ACK:
            begin
               ack_now <= 1'b0;
               bit_cnt <= 4'h0;
               state <= ret_state;
            end
            ivcc_pkg::IVCC_RDATA:
            begin
               if (bit_cnt == 4'h8)
               begin
                  state <= ivcc_pkg::IVCC_RACK;
                  bit_cnt <= 4'h0;
               end
            end
            ivcc_pkg::IVCC_RACK:
               state <= ivcc_pkg::IVCC_SKIP;
            default:
               state <= state;
         endcase
      end
   end

   // SDA drive: ACK low, or the read byte MSB first, changed on SCL low.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sda_oe <= 1'b0;
      else if (state == ivcc_pkg::IVCC_RDATA && scl)
         sda_oe <= sda_oe; // Hold the read bit while SCL is high.
      else if (state == ivcc_pkg::IVCC_RDATA && bit_cnt != 4'h8)
         sda_oe <= !shreg[7 - bit_cnt[2:0]];
      else
         sda_oe <= ack_now;
   end

   // Open-drain: the data value driven is always low.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         sda_out <= 1'b1;
      else
         sda_out <= 1'b0;
   end

   // ==========================================================
   // Register writes at the data ACK, well inside 27 SCL periods.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         output_voltage_code <= {1'b1, ivcc_pkg::VOLTAGE_CODE_RESET};
         regulator_control <= ivcc_pkg::CONTROL_RESET;
         code_change <= 1'b0;
      end
      else
      begin
         code_change <= 1'b0;
         if (scl_fall && state == ivcc_pkg::IVCC_WDATA && bit_cnt == 4'h8)
         begin
            if (reg_ptr == ivcc_pkg::ADDR_VOLTAGE && parity_ok(shreg))
            begin
               output_voltage_code <= shreg;
               code_change <= 1'b1;
            end
            else if (reg_ptr == ivcc_pkg::ADDR_CONTROL)
               regulator_control <= shreg & ivcc_pkg::CTL_WRITE_MASK;
         end
      end
   end

   // ==========================================================
   // Enable, soft start, fault latch and power-ok.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         en_prev <= 1'b0;
         latched_off <= 1'b0;
      end
      else
      begin
         en_prev <= en_lvl;
         // A fault still present at the enable edge keeps the latch set.
         if (flt_lvl && regulator_control[ivcc_pkg::CTL_LATCH_OFF_BIT]
            && !protection_suspend)
            latched_off <= 1'b1;
         else if (en_lvl && !en_prev)
            latched_off <= 1'b0;
      end
   end

   // Soft-start counter runs while supply and enable are good and the fault latch is clear.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         ss_cnt <= 32'h0;
      else if (!(en_lvl && sup_lvl) || latched_off)
         ss_cnt <= 32'h0;
      else if (ss_cnt < SOFT_START_CYCLES)
         ss_cnt <= ss_cnt + 32'h1;
   end

   // Registered control outputs.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         voltage_code <= ivcc_pkg::VOLTAGE_CODE_RESET;
         use_register_code <= 1'b0;
         use_initial_setpoint_pin <= 1'b1;
         protection_suspend <= 1'b0;
         light_load_select <= 1'b1;
         latch_off_mode <= 1'b1;
         regulator_on <= 1'b0;
         power_ok <= 1'b0;
      end
      else
      begin
         voltage_code <= output_voltage_code[6:0];
         use_register_code <= regulator_control[ivcc_pkg::CTL_INTERNAL_BIT];
         use_initial_setpoint_pin <= !regulator_control[ivcc_pkg::CTL_INTERNAL_BIT];
         protection_suspend <= code_change
            && regulator_control[ivcc_pkg::CTL_PROT_MASK_BIT];
         light_load_select <= regulator_control[ivcc_pkg::CTL_LIGHT_LOAD_BIT];
         latch_off_mode <= regulator_control[ivcc_pkg::CTL_LATCH_OFF_BIT];
         regulator_on <= en_lvl && sup_lvl && !latched_off
            && !(flt_lvl && !protection_suspend);
         power_ok <= (ss_cnt >= SOFT_START_CYCLES) && !flt_lvl;
      end
   end

endmodule

`default_nettype wire

// ### pkg/ivcc_pkg.sv
// Constants shared by the serial control port of the regulator.
// Assumes a single 40 MHz clock domain and an active-low asynchronous reset.
`default_nettype none

package ivcc_pkg;

   // ==========================================================
   // Register map
   localparam logic [7:0] ADDR_VOLTAGE = 8'h00;
   localparam logic [7:0] ADDR_CONTROL = 8'h01;

   // ==========================================================
   // Field positions
   localparam int PARITY_BIT = 7;
   localparam int CTL_INTERNAL_BIT = 7;
   localparam int CTL_PROT_MASK_BIT = 4;
   localparam int CTL_LIGHT_LOAD_BIT = 3;
   localparam int CTL_LATCH_OFF_BIT = 0;
   localparam logic [7:0] CTL_WRITE_MASK = 8'h99;

   // ==========================================================
   // Reset values
   localparam logic [6:0] VOLTAGE_CODE_RESET = 7'h32;
   localparam logic [7:0] CONTROL_RESET = 8'h09;

   // ==========================================================
   // Timing
   localparam int CLK_HZ = 40000000;
   localparam int SOFT_START_MS = 4;
   localparam int SOFT_START_CYCLES = CLK_HZ / 1000 * SOFT_START_MS;
   localparam int RESPONSE_SCL_PERIODS = 27;
   localparam int I2C_FAST_HZ = 400000;
   localparam int I2C_STD_HZ = 100000;

   // ==========================================================
   // Serial port states
   typedef enum logic [2:0] {
      IVCC_IDLE = 3'b000,
      IVCC_ADDR = 3'b001,
      IVCC_REG = 3'b010,
      IVCC_WDATA = 3'b011,
      IVCC_RDATA = 3'b100,
      IVCC_ACK = 3'b101,
      IVCC_RACK = 3'b110,
      IVCC_SKIP = 3'b111
   } ivcc_state_t;

endpackage

`default_nettype wire

// ### rtl/ivcc_sync.sv
// Three-stage synchroniser with agreement filter for one pin.
// Assumes the pin is asynchronous to clk.
`timescale 1ns/100ps
`default_nettype none

module ivcc_sync
#(
   parameter logic RESET_LEVEL = 1'b1
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Pin and filtered level
   input wire logic pin,
   output logic level
);

   logic [2:0] stage;

   // ==========================================================
   // Shift the pin through three flops.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         stage <= {3{RESET_LEVEL}};
      else
         stage <= {stage[1:0], pin};
   end

   // A change counts once the second and third flops agree.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         level <= RESET_LEVEL;
      else if (stage[1] == stage[2])
         level <= stage[2];
   end

endmodule

`default_nettype wire

// ### bench/ivcc_port_monitor.sv
// Checker for the serial control port, bound to ivcc_port.
// Assumes one clock domain and sees only the port's pins.
`timescale 1ns/100ps
`default_nettype none

module ivcc_port_monitor
#(
   parameter int SOFT_START_CYCLES = ivcc_pkg::SOFT_START_CYCLES
)
(
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // I2C pins
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   // Status pins
   input wire logic enable_pin,
   input wire logic supply_ok,
   input wire logic fault,
   // Control outputs
   input wire logic [6:0] voltage_code,
   input wire logic use_register_code,
   input wire logic use_initial_setpoint_pin,
   input wire logic protection_suspend,
   input wire logic light_load_select,
   input wire logic latch_off_mode,
   input wire logic regulator_on,
   input wire logic power_ok
);
   // ==========================================================
   // Helper logic
   int on_cnt;

   // Counts how long the regulator has been on, saturating.
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         on_cnt <= 0;
      else if (!regulator_on)
         on_cnt <= 0;
      else if (on_cnt < SOFT_START_CYCLES)
         on_cnt <= on_cnt + 1;
   end

   // ==========================================================
   // Properties
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   property p_ack_low; sda_oe |-> !sda_out; endproperty
   a_ack_low: assert property (p_ack_low) else $error("SDA driven high");
   property p_reset_code; $rose(rst_n) |-> voltage_code == 7'h32; endproperty
   a_reset_code: assert property (p_reset_code) else $error("bad reset code");
   property p_src; use_initial_setpoint_pin != use_register_code; endproperty
   a_src: assert property (p_src) else $error("source select clash");
   property p_code_ack; $changed(voltage_code) |-> ##[0:8] sda_oe; endproperty
   a_code_ack: assert property (p_code_ack) else $error("code moved without ack");
   property p_ctl_ack;
      $changed({use_register_code, light_load_select, latch_off_mode}) |-> ##[0:8] sda_oe;
   endproperty
   a_ctl_ack: assert property (p_ctl_ack) else $error("control moved without ack");
   property p_oe_scl; $changed(sda_oe) |-> !scl_in; endproperty
   a_oe_scl: assert property (p_oe_scl) else $error("SDA moved while SCL high");
   property p_suspend; protection_suspend |=> !protection_suspend; endproperty
   a_suspend: assert property (p_suspend) else $error("suspend pulse too long");
   property p_pg_on;
      $rose(power_ok) |-> regulator_on && on_cnt >= SOFT_START_CYCLES / 2;
   endproperty
   a_pg_on: assert property (p_pg_on) else $error("power ok too early");
   property p_pg_fault; $rose(fault) |-> ##[1:8] !power_ok; endproperty
   a_pg_fault: assert property (p_pg_fault) else $error("power ok kept on fault");

   // Main scenarios reached.
   c_ack: cover property (sda_oe);
   c_suspend: cover property ($rose(protection_suspend));
   c_pg: cover property ($rose(power_ok));
endmodule

bind ivcc_port ivcc_port_monitor #(.SOFT_START_CYCLES(SOFT_START_CYCLES)) mon_u (
   .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .enable_pin(enable_pin), .supply_ok(supply_ok), .fault(fault),
   .voltage_code(voltage_code), .use_register_code(use_register_code),
   .use_initial_setpoint_pin(use_initial_setpoint_pin),
   .protection_suspend(protection_suspend), .light_load_select(light_load_select),
   .latch_off_mode(latch_off_mode), .regulator_on(regulator_on), .power_ok(power_ok));

`default_nettype wire

// ### bench/ivcc_master_model.sv
// Behavioural I2C bus master driving the control port.
// Assumes SDA is resolved outside with a pull-up; SCL idles high.
`timescale 1ns/100ps
`default_nettype none

module ivcc_master_model
(
   // Clock
   input wire logic clk,
   // Bus lines
   input wire logic sda_wire,
   output logic scl,
   output logic sda_drv
);
   int q = 25; // Quarter bit in clocks; 25 is the fastest rate allowed.

   // Lines released and clock standing high outside frames.
   initial
   begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   // Waits a quarter bit, moving lines only after the edge.
   task automatic tick();
      repeat (q) @(posedge clk);
      #2;
   endtask

   // One bit: data set with SCL low, sampled mid high phase.
   task automatic bit_io(input logic b, output logic r);
      sda_drv = b;
      tick();
      scl = 1'b1;
      tick();
      r = sda_wire;
      tick();
      scl = 1'b0;
      tick();
   endtask

   // START and STOP conditions.
   task automatic start();
      sda_drv = 1'b1;
      scl = 1'b1;
      tick();
      sda_drv = 1'b0;
      tick();
      scl = 1'b0;
      tick();
   endtask

   task automatic stop();
      sda_drv = 1'b0;
      tick();
      scl = 1'b1;
      tick();
      sda_drv = 1'b1;
      tick();
   endtask

   // Sends a byte MSB first and returns whether it was acknowledged.
   task automatic wbyte(input logic [7:0] d, output logic ak);
      logic r;
      for (int i = 7; i >= 0; i--)
         bit_io(d[i], r);
      bit_io(1'b1, r);
      ak = ~r;
   endtask

   // Pointer byte goes ahead of the data byte.
   task automatic wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] v,
                     output logic [2:0] ak);
      start();
      wbyte({a, 1'b0}, ak[2]);
      wbyte(p, ak[1]);
      wbyte(v, ak[0]);
      stop();
   endtask

   // Reads one byte and ends it with a not-acknowledge.
   task automatic rd(input logic [6:0] a, output logic [7:0] d, output logic ak);
      logic r;
      start();
      wbyte({a, 1'b1}, ak);
      for (int i = 7; i >= 0; i--)
         bit_io(1'b1, d[i]);
      bit_io(1'b1, r);
      stop();
   endtask
endmodule

`default_nettype wire

// ### bench/tb_i2c_voltage_code_control.sv
// Self-checking bench for the serial control port.
// Assumes the master model and the bound checker are compiled alongside.
`timescale 1ns/100ps
`default_nettype none

module tb_i2c_voltage_code_control;
   localparam logic [6:0] ADDR = 7'h36;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   logic enable_pin = 1'b1;
   logic supply_ok = 1'b1;
   logic fault = 1'b0;
   logic scl, sda_drv, sda_out, sda_oe, use_register_code, use_initial_setpoint_pin;
   logic protection_suspend, light_load_select, latch_off_mode, regulator_on, power_ok;
   logic [6:0] voltage_code;
   logic [7:0] rd_val;
   logic [2:0] acks;
   logic ack1;
   logic [7:0] ctl [3] = '{8'hFF, 8'h00, 8'h10};
   int err_count = 0;
   int n_checks = 0;
   int cyc = 0;
   int sus = 0;
   wire sda = sda_drv & ~(sda_oe & ~sda_out);

   // ==========================================================
   // Design, master and clock
   ivcc_port #(.DEVICE_ADDR(ADDR), .SOFT_START_CYCLES(50)) dut_u (
      .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
      .sda_oe(sda_oe), .enable_pin(enable_pin), .supply_ok(supply_ok), .fault(fault),
      .voltage_code(voltage_code), .use_register_code(use_register_code),
      .use_initial_setpoint_pin(use_initial_setpoint_pin),
      .protection_suspend(protection_suspend), .light_load_select(light_load_select),
      .latch_off_mode(latch_off_mode), .regulator_on(regulator_on), .power_ok(power_ok));
   ivcc_master_model m_u (.clk(clk), .sda_wire(sda), .scl(scl), .sda_drv(sda_drv));

   always #12.5 clk = ~clk;

   // Counts cycles and suspend pulses, and cuts a hang short.
   always @(posedge clk)
   begin
      cyc++;
      if (protection_suspend === 1'b1)
         sus++;
      if (cyc == 90000)
      begin
         err_count++;
         finish_test();
      end
   end

   // ==========================================================
   // Tasks
   task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         err_count++;
         $display("ERROR %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wcyc(input int n);
      repeat (n) @(posedge clk);
      #2;
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, err_count);
      if (err_count == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // ==========================================================
   // Test sequence
   initial
   begin
      wcyc(2);
      rst_n = 1'b1;
      wcyc(10);
      chk("code", {1'b0, voltage_code}, 8'h32);
      chk("pins", {use_register_code, use_initial_setpoint_pin, light_load_select,
          latch_off_mode, power_ok}, 8'h0E);
      m_u.rd(ADDR, rd_val, ack1);
      chk("read ack", {7'h00, ack1}, 8'h01);
      chk("read 00", rd_val, 8'hB2);
      $display("reset test done");
      // Parity bit is the XNOR of the seven code bits, so 0x55 is refused.
      m_u.wr(ADDR, 8'h00, 8'hD5, acks);
      chk("write ack", acks, 8'h07);
      chk("code", voltage_code, 8'h55);
      m_u.rd(ADDR, rd_val, ack1);
      chk("read back", rd_val, 8'hD5);
      m_u.wr(ADDR, 8'h00, 8'h55, acks);
      chk("parity ack", acks, 8'h06);
      m_u.wr(ADDR, 8'h00, 8'hD5, acks);
      chk("resend ack", acks, 8'h07);
      m_u.wr(ADDR ^ 7'h01, 8'h00, 8'h83, acks);
      chk("foreign ack", acks, 8'h00);
      m_u.wr(ADDR, 8'h02, 8'h83, acks);
      chk("pointer ack", acks, 8'h06);
      chk("code kept", voltage_code, 8'h55);
      $display("voltage test done");
      foreach (ctl[i])
      begin
         m_u.wr(ADDR, 8'h01, ctl[i], acks);
         chk("ctl ack", acks, 8'h07);
         chk("ctl pins", {use_register_code, use_initial_setpoint_pin, light_load_select,
             latch_off_mode}, {ctl[i][7], ~ctl[i][7], ctl[i][3], ctl[i][0]});
         m_u.rd(ADDR, rd_val, ack1);
         chk("ctl read", rd_val, ctl[i] & 8'h99);
      end
      $display("control test done");
      m_u.q = 100;
      m_u.wr(ADDR, 8'h00, 8'h83, acks);
      m_u.q = 25;
      chk("slow ack", acks, 8'h07);
      chk("slow code", voltage_code, 8'h03);
      chk("suspend", sus[7:0], 8'h01);
      $display("rate test done");
      chk("power", {regulator_on, power_ok}, 8'h03);
      m_u.wr(ADDR, 8'h01, 8'h01, acks);
      fault = 1'b1;
      wcyc(20);
      fault = 1'b0;
      wcyc(50);
      chk("latched", {regulator_on, power_ok}, 8'h00);
      enable_pin = 1'b0;
      wcyc(20);
      enable_pin = 1'b1;
      wcyc(30);
      chk("soft start", {regulator_on, power_ok}, 8'h02);
      wcyc(80);
      chk("restart", {regulator_on, power_ok}, 8'h03);
      $display("power test done");
      finish_test();
   end
endmodule

`default_nettype wire
